// File: hw/bcp_defines.vh
/*
 * constants of the bridge control / express capability header block:
 * offsets, field positions, reset values, decode ranges.
 * assumes it is included once per design file by its bare name.
 */
`ifndef BCP_DEFINES_VH
`define BCP_DEFINES_VH

// register indices; byte address is four times the index
`define BCP_IDX_BRIDGE_CONTROL 12'h03e
`define BCP_IDX_CAP 12'h040
`define BCP_IDX_IRQ_STAT 12'h050
`define BCP_IDX_IRQ_MASK 12'h051
`define BCP_ADR_BRIDGE_CONTROL 12'h0f8
`define BCP_ADR_CAP 12'h100
`define BCP_ADR_IRQ_STAT 12'h140
`define BCP_ADR_IRQ_MASK 12'h144

// bridge control bit positions
`define BCP_BC_PERR 0
`define BCP_BC_SERR 1
`define BCP_BC_ISA 2
`define BCP_BC_VGA 3
`define BCP_BC_VGA16 4
`define BCP_BC_SBR 6
`define BCP_BC_WMASK 16'h005f

// capability header fields and reset values
`define BCP_CAP_ID 8'h10
`define BCP_NXT_RST 8'hc0
`define BCP_VER_RST 4'h1
`define BCP_TYPE_UP 4'h5
`define BCP_TYPE_DN 4'h6
`define BCP_SLOT_RST 1'b0
`define BCP_IMN_VAL 5'h00
`define BCP_TCS_RST 1'b1

// interrupt status bits
`define BCP_IRQ_POISON 0
`define BCP_IRQ_ERRFWD 1
`define BCP_IRQ_SBR 2
`define BCP_IRQ_W 3

// isa and vga decode ranges
`define BCP_ISA_TOP 16'hffff
`define BCP_VGA_IO0_LO 10'h3b0
`define BCP_VGA_IO0_HI 10'h3bb
`define BCP_VGA_IO1_LO 10'h3c0
`define BCP_VGA_IO1_HI 10'h3df
`define BCP_VGA_MEM_LO 32'h000a0000
`define BCP_VGA_MEM_HI 32'h000bffff

`endif

// File: hw/bcp_io_route.v
/*
 * i/o and vga routing decision for one request, answered one
 * cycle after the request strobe.
 * assumes the window hit comes from base/limit logic on core_clk.
 */
`default_nettype none
`include "bcp_defines.vh"

module bcp_io_route (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // routing controls
    input wire isa_routing_enable,
    input wire vga_forward_enable,
    input wire vga_sixteen_bit_decode,
    // request
    input wire req,
    input wire req_is_io,
    input wire [31:0] req_addr,
    input wire req_in_window,
    // answer
    output reg rsp_vld_ff,
    output reg fwd_down_ff,
    output reg fwd_up_ff
);

    ////////////////////////////////////////////////////////////////
    // vga i/o hit; 10-bit mode aliases every 1 kb of i/o space
    function vga_io_hit;
        input [31:0] a;
        input wide;
        reg [9:0] lo;
        begin
            lo = a[9:0];
            vga_io_hit = ((lo >= `BCP_VGA_IO0_LO && lo <= `BCP_VGA_IO0_HI) ||
                (lo >= `BCP_VGA_IO1_LO && lo <= `BCP_VGA_IO1_HI)) &&
                (!wide || a[31:10] == 22'h000000);
        end
    endfunction

    reg isa_hole; // upper 768 bytes of a 1 kb block, first 64 kb
    reg vga_hit; // vga compatible address
    reg nxt_down;
    reg nxt_up;

    ////////////////////////////////////////////////////////////////
    // combinational routing
    always @* begin
        isa_hole = (req_addr[31:16] == 16'h0000) && (req_addr[9:8] != 2'b00);
        // width bit only matters with vga forwarding on
        vga_hit = vga_forward_enable && (req_is_io ?
            vga_io_hit(req_addr, vga_sixteen_bit_decode) :
            (req_addr >= `BCP_VGA_MEM_LO && req_addr <= `BCP_VGA_MEM_HI));
        nxt_down = 1'b0;
        nxt_up = 1'b0;
        if (vga_hit) begin
            nxt_down = 1'b1;
        end else if (req_is_io && req_in_window) begin
            if (isa_routing_enable && isa_hole) begin
                nxt_up = 1'b1;
            end else begin
                nxt_down = 1'b1;
            end
        end else begin
            nxt_up = 1'b1; // outside the window goes back up
        end
    end

    ////////////////////////////////////////////////////////////////
    // registered answer
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_vld_ff <= 1'b0;
            fwd_down_ff <= 1'b0;
            fwd_up_ff <= 1'b0;
        end else begin
            rsp_vld_ff <= req;
            fwd_down_ff <= req & nxt_down;
            fwd_up_ff <= req & nxt_up;
        end
    end

endmodule // bcp_io_route
`default_nettype wire

// File: hw/bcp_port_cfg.v
/*
 * configuration logic of one switch port: bridge control register,
 * express capability header, event forwarding, secondary bus reset,
 * interrupt status and mask.
 * assumes one clock core_clk, an async active-high reset, a master
 * that never waits and an upstream strap pin from outside.
 */
`default_nettype none
`include "bcp_defines.vh"

module bcp_port_cfg (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // register port
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire reg_load_wr,
    output reg [31:0] reg_rdata_ff,
    // strap pin
    input wire port_is_upstream_pin,
    // error enables from command and device control
    input wire cmd_serr_en,
    input wire devctl_err_en,
    // secondary side events
    input wire sec_poison_det,
    input wire sec_err_cor,
    input wire sec_err_nonfatal,
    input wire sec_err_fatal,
    // primary side reports
    output reg poison_report_ff,
    output reg pri_err_cor_ff,
    output reg pri_err_nonfatal_ff,
    output reg pri_err_fatal_ff,
    // secondary bus reset
    output wire secondary_bus_reset,
    output wire sbr_is_upstream,
    // routing request and answer
    input wire route_req,
    input wire route_is_io,
    input wire [31:0] route_addr,
    input wire route_in_window,
    output wire route_vld,
    output wire route_down,
    output wire route_up,
    // interrupt
    output wire irq
);

    ////////////////////////////////////////////////////////////////
    // state
    reg [15:0] bridge_control_ff; // bridge control
    reg [7:0] nxt_ptr_ff; // next capability pointer
    reg [3:0] cap_ver_ff; // capability version
    reg slot_ff; // slot implemented
    reg tcs_ff; // traffic class routing supported
    reg [`BCP_IRQ_W-1:0] irq_stat_ff; // sticky events
    reg [`BCP_IRQ_W-1:0] irq_mask_ff; // one enables
    reg strap_s1_ff; // strap sync stage one
    reg strap_s2_ff; // strap sync stage two
    reg [1:0] strap_cnt_ff; // edges since reset release
    reg upstream_ff; // captured port role

    // named control bits
    wire parity_error_response_enable;
    wire system_error_forward_enable;
    wire isa_routing_enable;
    wire vga_forward_enable;
    wire vga_sixteen_bit_decode;
    wire err_path_open; // forward bit plus either upstream enable
    wire sbr_set; // reset bit written from zero to one
    wire [31:0] cap_word; // assembled capability header
    wire [3:0] port_type;

    reg [31:0] nxt_rdata;
    reg [`BCP_IRQ_W-1:0] nxt_stat;
    reg [`BCP_IRQ_W-1:0] ev_set;

    ////////////////////////////////////////////////////////////////
    // address match helpers
    function hit;
        input [11:0] a;
        input [11:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    assign parity_error_response_enable = bridge_control_ff[`BCP_BC_PERR];
    assign system_error_forward_enable = bridge_control_ff[`BCP_BC_SERR];
    assign isa_routing_enable = bridge_control_ff[`BCP_BC_ISA];
    assign vga_forward_enable = bridge_control_ff[`BCP_BC_VGA];
    assign vga_sixteen_bit_decode = bridge_control_ff[`BCP_BC_VGA16];

    ////////////////////////////////////////////////////////////////
    // strap capture; sync first, catch after reset release so
    // the async reset never loads a pin value
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_s1_ff <= 1'b0;
            strap_s2_ff <= 1'b0;
            strap_cnt_ff <= 2'h0;
            upstream_ff <= 1'b0;
        end else begin
            strap_s1_ff <= port_is_upstream_pin;
            strap_s2_ff <= strap_s1_ff;
            // hold the role after the sync stages settle
            if (strap_cnt_ff != 2'h3) begin
                strap_cnt_ff <= strap_cnt_ff + 2'h1;
                upstream_ff <= strap_s2_ff;
            end
        end
    end

    assign port_type = upstream_ff ? `BCP_TYPE_UP : `BCP_TYPE_DN;

    ////////////////////////////////////////////////////////////////
    // bridge control; ordinary writes reach only defined bits
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bridge_control_ff <= 16'h0000;
        end else if (reg_wr && hit(reg_addr, `BCP_ADR_BRIDGE_CONTROL)) begin
            // reserved bits 5 and 15:7 stay zero
            bridge_control_ff <= reg_wdata[15:0] & `BCP_BC_WMASK;
        end
    end

    // reset bit newly set by this write
    assign sbr_set = reg_wr && hit(reg_addr, `BCP_ADR_BRIDGE_CONTROL) &&
        reg_wdata[`BCP_BC_SBR] && !bridge_control_ff[`BCP_BC_SBR];

    // reset holds as long as software leaves the bit set
    assign secondary_bus_reset = bridge_control_ff[`BCP_BC_SBR];
    // upstream port resets upstream, downstream its own bus
    assign sbr_is_upstream = upstream_ff;

    ////////////////////////////////////////////////////////////////
    // loadable capability fields; the load strobe is the only way
    // in, so a plain write to the header has no effect
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nxt_ptr_ff <= `BCP_NXT_RST;
            cap_ver_ff <= `BCP_VER_RST;
            slot_ff <= `BCP_SLOT_RST;
            tcs_ff <= `BCP_TCS_RST;
        end else if (reg_load_wr && hit(reg_addr, `BCP_ADR_CAP)) begin
            nxt_ptr_ff <= reg_wdata[15:8];
            cap_ver_ff <= reg_wdata[19:16];
            // slot has no meaning on the upstream port
            slot_ff <= reg_wdata[24] & ~upstream_ff;
            tcs_ff <= reg_wdata[30];
        end
    end

    // fixed fields, reserved bit 31 zero
    assign cap_word = {1'b0, tcs_ff, `BCP_IMN_VAL, slot_ff,
        port_type, cap_ver_ff, nxt_ptr_ff, `BCP_CAP_ID};

    ////////////////////////////////////////////////////////////////
    // poison reporting on the secondary interface
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            poison_report_ff <= 1'b0;
        end else begin
            // ignored for reporting while the bit is clear
            poison_report_ff <= sec_poison_det & parity_error_response_enable;
        end
    end

    ////////////////////////////////////////////////////////////////
    // error message forwarding to the primary side
    assign err_path_open = system_error_forward_enable &&
        (cmd_serr_en || devctl_err_en);

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pri_err_cor_ff <= 1'b0;
            pri_err_nonfatal_ff <= 1'b0;
            pri_err_fatal_ff <= 1'b0;
        end else begin
            pri_err_cor_ff <= sec_err_cor & err_path_open;
            pri_err_nonfatal_ff <= sec_err_nonfatal & err_path_open;
            pri_err_fatal_ff <= sec_err_fatal & err_path_open;
        end
    end

    ////////////////////////////////////////////////////////////////
    // i/o and vga routing
    bcp_io_route u_route (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .isa_routing_enable(isa_routing_enable),
        .vga_forward_enable(vga_forward_enable),
        .vga_sixteen_bit_decode(vga_sixteen_bit_decode),
        .req(route_req),
        .req_is_io(route_is_io),
        .req_addr(route_addr),
        .req_in_window(route_in_window),
        .rsp_vld_ff(route_vld),
        .fwd_down_ff(route_down),
        .fwd_up_ff(route_up)
    );

    ////////////////////////////////////////////////////////////////
    // interrupt status; a new event beats a clearing write
    always @* begin
        ev_set = {`BCP_IRQ_W{1'b0}};
        ev_set[`BCP_IRQ_POISON] = sec_poison_det & parity_error_response_enable;
        ev_set[`BCP_IRQ_ERRFWD] = (sec_err_cor | sec_err_nonfatal | sec_err_fatal)
            & err_path_open;
        ev_set[`BCP_IRQ_SBR] = sbr_set;
        nxt_stat = irq_stat_ff;
        if (reg_wr && hit(reg_addr, `BCP_ADR_IRQ_STAT)) begin
            // write one to clear
            nxt_stat = nxt_stat & ~reg_wdata[`BCP_IRQ_W-1:0];
        end
        nxt_stat = nxt_stat | ev_set;
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_stat_ff <= {`BCP_IRQ_W{1'b0}};
            irq_mask_ff <= {`BCP_IRQ_W{1'b0}};
        end else begin
            irq_stat_ff <= nxt_stat;
            if (reg_wr && hit(reg_addr, `BCP_ADR_IRQ_MASK)) begin
                irq_mask_ff <= reg_wdata[`BCP_IRQ_W-1:0];
            end
        end
    end

    // level output while any enabled event is pending
    assign irq = |(irq_stat_ff & irq_mask_ff);

    ////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read zero
    always @* begin
        nxt_rdata = 32'h00000000;
        if (hit(reg_addr, `BCP_ADR_BRIDGE_CONTROL)) begin
            nxt_rdata = {16'h0000, bridge_control_ff};
        end else if (hit(reg_addr, `BCP_ADR_CAP)) begin
            nxt_rdata = cap_word;
        end else if (hit(reg_addr, `BCP_ADR_IRQ_STAT)) begin
            nxt_rdata = {29'h00000000, irq_stat_ff};
        end else if (hit(reg_addr, `BCP_ADR_IRQ_MASK)) begin
            nxt_rdata = {29'h00000000, irq_mask_ff};
        end
    end

    // data stands only in the cycle after the read strobe
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_ff <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end else begin
            reg_rdata_ff <= 32'h00000000;
        end
    end

endmodule // bcp_port_cfg
`default_nettype wire

// File: bench/bcp_port_monitor.sv
/*
 * assertions on the pins of the port configuration block.
 * assumes it is bound to bcp_port_cfg: one clock, async high reset.
 */
`default_nettype none
module bcp_port_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_ff,
    // error enables and secondary events
    input wire logic cmd_serr_en,
    input wire logic devctl_err_en,
    input wire logic sec_poison_det,
    input wire logic sec_err_cor,
    input wire logic sec_err_nonfatal,
    input wire logic sec_err_fatal,
    // primary reports
    input wire logic poison_report_ff,
    input wire logic pri_err_cor_ff,
    input wire logic pri_err_nonfatal_ff,
    input wire logic pri_err_fatal_ff,
    // secondary reset and routing
    input wire logic secondary_bus_reset,
    input wire logic sbr_is_upstream,
    input wire logic route_req,
    input wire logic route_vld,
    input wire logic route_down,
    input wire logic route_up
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // either upstream enable lets forwarded errors out
    wire logic err_en = cmd_serr_en | devctl_err_en;
    // shadow of the two enable bits, rebuilt from the register port
    logic perr_q;
    logic serr_q;
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            perr_q <= 1'b0;
            serr_q <= 1'b0;
        end else if (reg_wr && reg_addr == 12'h0f8) begin
            perr_q <= reg_wdata[0];
            serr_q <= reg_wdata[1];
        end
    end
    ////////////////////////////////////////////////////////////////
    // register reads; the strap must have settled for the type
    sequence s_bridge_control_rd;
        reg_rd && reg_addr == 12'h0f8;
    endsequence
    sequence s_cap_rd;
        reg_rd && reg_addr == 12'h100 ##1 $stable(sbr_is_upstream);
    endsequence
    ////////////////////////////////////////////////////////////////
    a_poison_has_cause: assert property (poison_report_ff == $past(sec_poison_det && perr_q))
        else $error("poison report without a detect");
    a_cor_fwd_cause: assert property (pri_err_cor_ff == $past(sec_err_cor && err_en && serr_q))
        else $error("correctable forwarded without cause");
    a_nonfatal_fwd_cause: assert property (pri_err_nonfatal_ff == $past(sec_err_nonfatal && err_en && serr_q))
        else $error("nonfatal forwarded without cause");
    a_fatal_fwd_cause: assert property (pri_err_fatal_ff == $past(sec_err_fatal && err_en && serr_q))
        else $error("fatal forwarded without cause");
    a_bridge_control_reserved_zero: assert property (s_bridge_control_rd |=> (reg_rdata_ff & 32'hffffffa0) == 32'h0)
        else $error("bridge control reserved bits set");
    a_sbr_read_level: assert property (s_bridge_control_rd |=> reg_rdata_ff[6] == $past(secondary_bus_reset))
        else $error("reset bit and reset output differ");
    a_sbr_write_start: assert property (reg_wr && reg_addr == 12'h0f8 && reg_wdata[6] |=> secondary_bus_reset)
        else $error("secondary reset not started");
    a_cap_fixed_fields: assert property (s_cap_rd |-> reg_rdata_ff[7:0] == 8'h10 && !reg_rdata_ff[31] && reg_rdata_ff[29:25] == 5'h0)
        else $error("capability fixed fields wrong");
    a_cap_port_type: assert property (s_cap_rd |-> reg_rdata_ff[23:20] == (sbr_is_upstream ? 4'h5 : 4'h6))
        else $error("port type wrong");
    a_up_slot_zero: assert property (s_cap_rd |-> !(sbr_is_upstream && reg_rdata_ff[24]))
        else $error("slot bit set on upstream port");
    a_route_answer_time: assert property (route_vld == $past(route_req) && (route_vld ? route_down ^ route_up : !(route_down | route_up)))
        else $error("routing answer timing or direction wrong");
endmodule // bcp_port_monitor

bind bcp_port_cfg bcp_port_monitor i_bcp_port_monitor (
    .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
    .cmd_serr_en, .devctl_err_en, .sec_poison_det, .sec_err_cor, .sec_err_nonfatal,
    .sec_err_fatal, .poison_report_ff, .pri_err_cor_ff, .pri_err_nonfatal_ff,
    .pri_err_fatal_ff, .secondary_bus_reset, .sbr_is_upstream, .route_req,
    .route_vld, .route_down, .route_up
);
`default_nettype wire

// File: bench/bcp_port_cfg_bench.sv
/*
 * self-checking bench of the port configuration block with an integer model.
 * assumes a 200 MHz core clock, async high reset, master that never waits.
 */
`default_nettype none
module bcp_port_cfg_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // design inputs, all given a value at time zero
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic reg_load_wr = 1'b0;
    logic up_pin = 1'b0;
    logic cmd_en = 1'b0;
    logic dev_en = 1'b0;
    logic [3:0] sec_ev = 4'h0; // poison, cor, nonfatal, fatal
    logic route_req = 1'b0;
    logic route_io = 1'b0;
    logic [31:0] route_addr = 32'h0;
    logic route_win = 1'b0;
    // design outputs
    wire logic [31:0] rdata;
    wire logic [3:0] pri_ev;
    wire logic sbr, sbr_up, r_vld, r_down, r_up, irq;
    // model state and bookkeeping
    int bridge_control, stat, mask, cap_ld, up, d, j, k;
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 32'h913a;
    logic [31:0] base, ra;
    logic [1:0] q[$];
    logic [1:0] e;

    always #2.5 core_clk = ~core_clk;

    bcp_port_cfg i_bcp_port_cfg (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_load_wr(reg_load_wr), .reg_rdata_ff(rdata),
        .port_is_upstream_pin(up_pin), .cmd_serr_en(cmd_en), .devctl_err_en(dev_en),
        .sec_poison_det(sec_ev[0]), .sec_err_cor(sec_ev[1]),
        .sec_err_nonfatal(sec_ev[2]), .sec_err_fatal(sec_ev[3]),
        .poison_report_ff(pri_ev[0]), .pri_err_cor_ff(pri_ev[1]),
        .pri_err_nonfatal_ff(pri_ev[2]), .pri_err_fatal_ff(pri_ev[3]),
        .secondary_bus_reset(sbr), .sbr_is_upstream(sbr_up), .route_req(route_req),
        .route_is_io(route_io), .route_addr(route_addr), .route_in_window(route_win),
        .route_vld(r_vld), .route_down(r_down), .route_up(r_up), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////
    // comparisons and verdict
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // model: loaded capability bits plus the fixed id and port type
    function automatic logic [31:0] cap_exp();
        return cap_ld | 32'h10 | (up ? 32'h500000 : 32'h600000);
    endfunction
    // {down, up}: vga hit first, then isa holes of the io window
    function automatic logic [1:0] route_exp(input int b, input logic io,
                                             input logic [31:0] a, input logic w);
        logic vga;
        vga = io ? (((a[9:0] >= 10'h3b0 && a[9:0] <= 10'h3bb) ||
                     (a[9:0] >= 10'h3c0 && a[9:0] <= 10'h3df)) && (!b[4] || a[31:10] == 22'h0))
                 : (a >= 32'h000a0000 && a <= 32'h000bffff);
        if (b[3] && vga) return 2'b10;
        if (io && w) return (b[2] && a[31:16] == 16'h0 && a[9:8] != 2'h0) ? 2'b01 : 2'b10;
        return 2'b01;
    endfunction

    ////////////////////////////////////////////////////////////////
    // one bus cycle: kind bit0 write, bit1 read, bit2 load
    task automatic bus(input logic [2:0] kind, input logic [11:0] a, input logic [31:0] dv);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= dv;
        reg_wr <= kind[0];
        reg_rd <= kind[1];
        reg_load_wr <= kind[2];
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_load_wr <= 1'b0;
        #1;
        if (kind[0] && a == 12'h0f8) begin
            if (!bridge_control[6] && dv[6]) stat |= 4;
            bridge_control = dv & 32'h5f;
        end
        if (kind[0] && a == 12'h140) stat &= ~dv;
        if (kind[0] && a == 12'h144) mask = dv & 7;
        if (kind[2] && a == 12'h100) cap_ld = dv & (up ? 32'h400fff00 : 32'h410fff00);
        chk_bit({3'h0, irq}, {3'h0, (stat & mask) != 0});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(3'h2, a, 32'h0);
        chk_word(rdata, exp);
    endtask
    // reset held four cycles, then four more for the strap to freeze
    task automatic do_reset(input logic pin);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        up_pin <= pin;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        bridge_control = 0;
        stat = 0;
        mask = 0;
        cap_ld = 32'h4001c000;
        up = pin;
    endtask

    // hang guard
    initial begin
        #400000;
        n_mismatch++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b0);
        rd(12'h0f8, 32'h0);
        rd(12'h100, cap_exp());
        rd(12'h200, 32'h0);
        bus(3'h1, 12'h204, $random(seed));
        repeat (6) begin
            d = $random(seed);
            bus(3'h1, 12'h0f8, d);
            chk_bit({2'h0, sbr_up, sbr}, {3'h0, bridge_control[6]});
            rd(12'h0f8, bridge_control);
            bus(3'h1, 12'h100, ~d);
            bus(3'h4, 12'h100, d);
            rd(12'h100, cap_exp());
        end
        // secondary events under every enable combination
        for (k = 0; k < 16; k++) begin
            d = $random(seed);
            bus(3'h1, 12'h144, d);
            rd(12'h144, mask);
            bus(3'h1, 12'h0f8, k & 3);
            @(posedge core_clk);
            cmd_en <= k[2];
            dev_en <= k[3];
            sec_ev <= d[7:4];
            @(posedge core_clk);
            sec_ev <= 4'h0;
            #1;
            e = {1'b0, d[4] & k[0]};
            chk_bit(pri_ev, {d[7:5] & {3{k[1] & (k[2] | k[3])}}, e[0]});
            if (e[0]) stat |= 1;
            if ((|d[7:5]) && k[1] && (k[2] | k[3])) stat |= 2;
            rd(12'h140, stat);
            bus(3'h1, 12'h140, d >> 8);
        end
        // back-to-back routing requests for every routing setting
        for (j = 0; j < 8; j++) begin
            bus(3'h1, 12'h0f8, j << 2);
            for (k = 0; k <= 12; k++) begin
                @(posedge core_clk);
                d = $random(seed);
                base = $random(seed);
                case (d[2:1])
                    2'd0: ra = {base[31:10] & {22{d[3]}}, 10'h3b0 + 10'(d[9:4])};
                    2'd1: ra = (d[3] ? 32'h000a0000 : 32'h000c0000) - 32'(d[5:4]);
                    2'd2: ra = base & 32'h0000ffff;
                    default: ra = base;
                endcase
                route_req <= (k < 12);
                route_io <= d[0];
                route_addr <= ra;
                route_win <= d[10];
                if (k < 12) q.push_back(route_exp(j << 2, d[0], ra, d[10]));
                #1;
                if (k > 0) begin
                    e = q.pop_front();
                    chk_bit({1'b0, r_vld, r_down, r_up}, {2'b01, e});
                end
            end
        end
        // upstream strap: type and slot bit
        do_reset(1'b1);
        chk_bit({3'h0, sbr_up}, 4'h1);
        bus(3'h4, 12'h100, 32'hffffffff);
        rd(12'h100, cap_exp());
        print_verdict();
    end
endmodule // bcp_port_cfg_bench
`default_nettype wire
